// ### verilog/ext_mode_defines.vh
// Purpose: Shared constants of the extended mode register decoder
// Assumes: Included by bare name from every design file
// Notes:   Bit positions refer to the address bus of the command bus
`ifndef EXT_MODE_DEFINES_VH
`define EXT_MODE_DEFINES_VH

// Extended register one field positions
`define EMR1_QOFF_BIT      12
`define EMR1_DQSN_DIS_BIT  10
`define EMR1_CAL_HI        9
`define EMR1_CAL_LO        7
`define EMR1_AL_HI         5
`define EMR1_AL_LO         3

// Calibration field codes
`define CAL_EXIT           3'h0
`define CAL_DRIVE_HIGH     3'h1
`define CAL_DRIVE_LOW      3'h2
`define CAL_ADJUST         3'h4
`define CAL_DEFAULT        3'h7

// Largest additive latency code that is not reserved
`define AL_MAX_CODE        3'h5

// Bank select codes {bank_addr_1, bank_addr_0}
`define BANK_EMR2          2'h2
`define BANK_EMR3          2'h3

// Reset values
`define RST_AL             3'h0
`define RST_CAL            3'h0
`define RST_REG16          16'h0000

// Timing counts in clock cycles and the default strength step
`define MODE_SET_CYCLES    2
`define CAL_OUT_DELAY_CYC  2
`define DEFAULT_STEP       4'h8

`endif

// ### verilog/sat_step_counter.v
// Purpose: Saturating strength step counter for one driver half
// Assumes: inc and dec never both high; load wins over both
// Notes:   Holds at the end of the range instead of wrapping
`timescale 1ns/100ps
`include "ext_mode_defines.vh"

module sat_step_counter #(
  parameter       WIDTH = 4
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             sys_rst_i,
  // Control
  input  wire             load_i,
  input  wire [WIDTH-1:0] load_val_i,
  input  wire             inc_i,
  input  wire             dec_i,
  // State
  output reg  [WIDTH-1:0] step_o
);

  localparam [WIDTH-1:0] TOP_STEP = {WIDTH{1'b1}};
  localparam [WIDTH-1:0] BOT_STEP = {WIDTH{1'b0}};
  localparam [WIDTH-1:0] ONE_STEP = {{(WIDTH-1){1'b0}}, 1'b1};

  // Load, step or hold with saturation
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      step_o <= load_val_i;  // Reset lands on the default step
    end else if (load_i) begin
      step_o <= load_val_i;
    end else if (inc_i && (step_o != TOP_STEP)) begin
      step_o <= step_o + ONE_STEP;
    end else if (dec_i && (step_o != BOT_STEP)) begin
      step_o <= step_o - ONE_STEP;
    end
  end

endmodule

// ### verilog/ext_mode_cal.v
// Purpose: Extended mode register writes and driver impedance calibration
// Assumes: Command pins sampled on clk_i; one adjust beat per clock
// Notes:   Column latency comes from the main mode register outside
//
// Contract
// - Decode register two write on bank 10
// - Mode set cycle time guards next command
// - Register two undefined until first write
// - Bit 12 disables all data and strobe outputs
// - Calibration field decodes exit, drive, adjust, default
// - Additive latency codes 0 to 5, rest reserved
// - Drive high and low patterns on data, strobes
// - Complement strobe drive follows its disable bit
// - One strength setting for all data lines
// - Sixteen saturating steps, default anywhere
// - Four-beat adjust code table
// - Code captured write latency after adjust command
// - Adjust command keeps previous additive latency
// - Beats taken in fixed order 0 to 3
// - Decode register one write on bank_addr_0 high and bank_addr_1 low
// - Bit 10 gives single-ended strobe
// - Drive outputs switch after calibration output delay
`timescale 1ns/100ps
`include "ext_mode_defines.vh"

module ext_mode_cal #(
  parameter DQ_WIDTH   = 16,
  parameter DQS_WIDTH  = 2,
  parameter STEP_WIDTH = 4,
  parameter MRD_CYC    = `MODE_SET_CYCLES,
  parameter OIT_CYC    = `CAL_OUT_DELAY_CYC,
  parameter [STEP_WIDTH-1:0] DEFAULT_STEP = `DEFAULT_STEP
) (
  // Clock and reset
  input  wire                  clk_i,
  input  wire                  sys_rst_i,
  // Command bus
  input  wire                  cs_n_i,
  input  wire                  ras_n_i,
  input  wire                  cas_n_i,
  input  wire                  we_n_i,
  input  wire                  bank_addr_0_i,
  input  wire                  bank_addr_1_i,
  input  wire [15:0]           addr_i,
  // Column latency and adjust code data
  input  wire [2:0]            column_latency_i,
  input  wire [DQ_WIDTH-1:0]   dq_i,
  // Register one state
  output reg                   output_off_o,
  output reg                   strobe_single_ended_o,
  output reg  [2:0]            additive_latency_o,
  output reg                   al_reserved_o,
  output reg  [2:0]            cal_mode_o,
  // Registers two and three
  output reg  [15:0]           emr2_o,
  output reg                   emr2_valid_o,
  output reg  [15:0]           emr3_o,
  // Command timing
  output reg                   mode_set_busy_o,
  output reg                   cmd_too_early_o,
  // Drivers, enables low while driving
  output reg  [DQ_WIDTH-1:0]   dq_o,
  output reg  [DQ_WIDTH-1:0]   dq_oe_n_o,
  output reg  [DQS_WIDTH-1:0]  dqs_o,
  output reg  [DQS_WIDTH-1:0]  dqs_oe_n_o,
  output reg  [DQS_WIDTH-1:0]  dqs_c_o,
  output reg  [DQS_WIDTH-1:0]  dqs_c_oe_n_o,
  // Strength settings
  output wire [STEP_WIDTH-1:0] pullup_step_o,
  output wire [STEP_WIDTH-1:0] pulldown_step_o,
  output reg                   adjust_reserved_o
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_BEAT = 2'h2;
  localparam [1:0] DRV_OFF  = 2'h0;
  localparam [1:0] DRV_HIGH = 2'h1;
  localparam [1:0] DRV_LOW  = 2'h2;
  localparam [3:0] MRD_LOAD = MRD_CYC[3:0] - 4'h1;
  localparam [3:0] OIT_LOAD = OIT_CYC[3:0] - 4'h1;

  // Adjust code to {pu_inc, pu_dec, pd_inc, pd_dec}; code[3] is beat 0
  function [3:0] adj_decode;
    input [3:0] code;
    begin
      case (code)
        4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'hA: begin
          adj_decode = {code[0], code[1], code[2], code[3]};
        end
        default: adj_decode = 4'h0;
      endcase
    end
  endfunction

  wire       mset     = !cs_n_i && !ras_n_i && !cas_n_i && !we_n_i;
  wire [1:0] bank     = {bank_addr_1_i, bank_addr_0_i};
  wire       emr1_wr  = mset && bank_addr_0_i && !bank_addr_1_i;
  wire       emr2_wr  = mset && (bank == `BANK_EMR2);
  wire       emr3_wr  = mset && (bank == `BANK_EMR3);
  wire [2:0] cal_fld  = addr_i[`EMR1_CAL_HI:`EMR1_CAL_LO];
  wire [2:0] al_fld   = addr_i[`EMR1_AL_HI:`EMR1_AL_LO];
  wire       any_cmd  = !cs_n_i && !(ras_n_i && cas_n_i && we_n_i);

  reg  [3:0]            mrd_cnt_reg;
  reg  [1:0]            drv_target_reg;
  reg  [1:0]            drv_level_reg;
  reg  [3:0]            oit_cnt_reg;
  reg                   oit_run_reg;
  reg  [1:0]            adj_state_reg;
  reg  [4:0]            adj_cnt_reg;
  reg  [1:0]            beat_reg;
  reg  [3:0]            code_reg;
  reg  [3:0]            adj_apply_reg;
  reg                   cal_load_reg;
  wire [4:0]            wl_cyc = {2'b00, additive_latency_o} + {2'b00, column_latency_i} - 5'h01;
  wire [3:0]            code_full = {code_reg[2:0], dq_i[0]};

  ////////////////////////////////////////////////////////////////////////
  // Register one, two and three storage
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      output_off_o          <= 1'b0;
      strobe_single_ended_o <= 1'b0;
      additive_latency_o    <= `RST_AL;
      al_reserved_o         <= 1'b0;
      cal_mode_o            <= `RST_CAL;
      emr2_o                <= `RST_REG16;
      emr2_valid_o          <= 1'b0;
      emr3_o                <= `RST_REG16;
    end else begin
      if (emr1_wr) begin
        output_off_o          <= addr_i[`EMR1_QOFF_BIT];
        strobe_single_ended_o <= addr_i[`EMR1_DQSN_DIS_BIT];
        cal_mode_o            <= cal_fld;
        if (cal_fld != `CAL_ADJUST) begin
          // Reserved latency codes keep the previous latency
          if (al_fld <= `AL_MAX_CODE) begin
            additive_latency_o <= al_fld;
          end
          al_reserved_o <= (al_fld > `AL_MAX_CODE);
        end
        // Adjust leaves the latency untouched
      end
      if (emr2_wr) begin
        emr2_o       <= addr_i;
        emr2_valid_o <= 1'b1;
      end
      if (emr3_wr) begin
        emr3_o <= addr_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode set cycle time guard
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      mrd_cnt_reg     <= 4'h0;
      mode_set_busy_o <= 1'b0;
      cmd_too_early_o <= 1'b0;
    end else begin
      cmd_too_early_o <= mode_set_busy_o && any_cmd;
      if (mset && MRD_CYC > 1) begin  // Main register writes arm it too
        mrd_cnt_reg     <= MRD_LOAD;
        mode_set_busy_o <= 1'b1;
      end else if (mrd_cnt_reg != 4'h0) begin
        mrd_cnt_reg     <= mrd_cnt_reg - 4'h1;
        mode_set_busy_o <= (mrd_cnt_reg != 4'h1);
      end else begin
        mode_set_busy_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drive mode target and output delay
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      drv_target_reg <= DRV_OFF;
      drv_level_reg  <= DRV_OFF;
      oit_cnt_reg    <= 4'h0;
      oit_run_reg    <= 1'b0;
    end else begin
      if (emr1_wr && (cal_fld == `CAL_DRIVE_HIGH || cal_fld == `CAL_DRIVE_LOW || cal_fld == `CAL_EXIT)) begin
        drv_target_reg <= cal_fld[1:0];  // Exit, high, low codes equal the levels
        oit_cnt_reg    <= OIT_LOAD;
        oit_run_reg    <= 1'b1;
      end else if (oit_run_reg) begin
        if (oit_cnt_reg == 4'h0) begin
          drv_level_reg <= drv_target_reg;
          oit_run_reg   <= 1'b0;
        end else begin
          oit_cnt_reg <= oit_cnt_reg - 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drivers from the applied drive level
  always @(posedge clk_i) begin
    if (sys_rst_i || output_off_o || drv_level_reg == DRV_OFF) begin
      dq_o         <= {DQ_WIDTH{1'b0}};
      dq_oe_n_o    <= {DQ_WIDTH{1'b1}};
      dqs_o        <= {DQS_WIDTH{1'b0}};
      dqs_oe_n_o   <= {DQS_WIDTH{1'b1}};
      dqs_c_o      <= {DQS_WIDTH{1'b0}};
      dqs_c_oe_n_o <= {DQS_WIDTH{1'b1}};
    end else begin
      dq_o         <= {DQ_WIDTH{drv_level_reg == DRV_HIGH}};
      dq_oe_n_o    <= {DQ_WIDTH{1'b0}};
      dqs_o        <= {DQS_WIDTH{drv_level_reg == DRV_HIGH}};
      dqs_oe_n_o   <= {DQS_WIDTH{1'b0}};
      dqs_c_o      <= {DQS_WIDTH{drv_level_reg == DRV_LOW}};
      dqs_c_oe_n_o <= {DQS_WIDTH{strobe_single_ended_o}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Adjust code capture, beat 0 at write latency
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      adj_state_reg     <= ST_IDLE;
      adj_cnt_reg       <= 5'h00;
      beat_reg          <= 2'h0;
      code_reg          <= 4'h0;
      adj_apply_reg     <= 4'h0;
      adjust_reserved_o <= 1'b0;
      cal_load_reg      <= 1'b0;
    end else begin
      adj_apply_reg <= 4'h0;
      cal_load_reg  <= emr1_wr && (cal_fld == `CAL_DEFAULT);
      case (adj_state_reg)
        ST_IDLE: begin
          if (emr1_wr && cal_fld == `CAL_ADJUST) begin
            adj_cnt_reg   <= wl_cyc - 5'h01;
            adj_state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (adj_cnt_reg == 5'h00) begin
            code_reg      <= {3'h0, dq_i[0]};
            beat_reg      <= 2'h1;
            adj_state_reg <= ST_BEAT;
          end else begin
            adj_cnt_reg <= adj_cnt_reg - 5'h01;
          end
        end
        ST_BEAT: begin
          code_reg <= code_full;
          beat_reg <= beat_reg + 2'h1;
          if (beat_reg == 2'h3) begin
            adj_apply_reg     <= adj_decode(code_full);
            adjust_reserved_o <= (adj_decode(code_full) == 4'h0) && (code_full != 4'h0);
            adj_state_reg     <= ST_IDLE;
          end
        end
        default: adj_state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pull-up counter in slot 1, pull-down in slot 0, shared by all data lines
  wire [2*STEP_WIDTH-1:0] step_bus;
  genvar                  k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_step
      sat_step_counter #(
        .WIDTH      (STEP_WIDTH)
      ) u_step (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .load_i     (cal_load_reg),
        .load_val_i (DEFAULT_STEP),
        .inc_i      (adj_apply_reg[2*k+1]),
        .dec_i      (adj_apply_reg[2*k]),
        .step_o     (step_bus[k*STEP_WIDTH +: STEP_WIDTH])
      );
    end
  endgenerate

  assign pullup_step_o   = step_bus[2*STEP_WIDTH-1:STEP_WIDTH];
  assign pulldown_step_o = step_bus[STEP_WIDTH-1:0];

endmodule

// ### sim/ext_mode_cal_properties.sv
// Purpose: Port-level checks of the extended mode decoder
// Assumes: Sees only top-level ports, one clock domain
// Notes:   Bound into every instance of the top module
`timescale 1ns/100ps
module ext_mode_cal_checker #(
  parameter DQ_WIDTH = 16,
  parameter DQS_WIDTH = 2,
  parameter STEP_WIDTH = 4,
  parameter [STEP_WIDTH-1:0] DEFAULT_STEP = 4'h8
) (
  // Clock, reset and command bus
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  cs_n_i,
  input wire logic                  ras_n_i,
  input wire logic                  cas_n_i,
  input wire logic                  we_n_i,
  input wire logic                  bank_addr_0_i,
  input wire logic                  bank_addr_1_i,
  input wire logic [15:0]           addr_i,
  // Observed outputs
  input wire logic                  output_off_o,
  input wire logic                  strobe_single_ended_o,
  input wire logic [2:0]            additive_latency_o,
  input wire logic [15:0]           emr2_o,
  input wire logic                  emr2_valid_o,
  input wire logic                  mode_set_busy_o,
  input wire logic                  cmd_too_early_o,
  input wire logic [DQ_WIDTH-1:0]   dq_o,
  input wire logic [DQ_WIDTH-1:0]   dq_oe_n_o,
  input wire logic [DQS_WIDTH-1:0]  dqs_o,
  input wire logic [DQS_WIDTH-1:0]  dqs_c_o,
  input wire logic [STEP_WIDTH-1:0] pullup_step_o,
  input wire logic [STEP_WIDTH-1:0] pulldown_step_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////
  // Command decode
  wire wr = !cs_n_i && !ras_n_i && !cas_n_i && !we_n_i;
  wire r1 = wr && !bank_addr_1_i && bank_addr_0_i;
  wire r2 = wr && bank_addr_1_i && !bank_addr_0_i;
  wire any_c = !cs_n_i && !(ras_n_i && cas_n_i && we_n_i);
  // Drive-high entry then four cycles without a register one write until pins settle
  sequence drv_hi_s;
    r1 && addr_i[9:7] == 3'h1 && !addr_i[12] && !addr_i[10] ##1 (!r1)[*4];
  endsequence
  // Default load then two quiet cycles
  sequence dflt_s;
    r1 && addr_i[9:7] == 3'h7 ##1 (!wr)[*2];
  endsequence
  busy_after_set_a: assert property (wr |=> mode_set_busy_o)
    else $error("busy not raised after mode set");
  qoff_capture_a: assert property (r1 |=> output_off_o == $past(addr_i[12]))
    else $error("output off bit not taken");
  strobe_mode_a: assert property (r1 |=> strobe_single_ended_o == $past(addr_i[10]))
    else $error("single-ended bit not taken");
  emr2_load_a: assert property (r2 |=> emr2_o == $past(addr_i) && emr2_valid_o)
    else $error("register two not loaded");
  al_code_a: assert property (r1 && addr_i[9:7] != 3'h4 && addr_i[5:3] <= 3'h5
    |=> additive_latency_o == $past(addr_i[5:3])) else $error("latency code not taken");
  al_keep_a: assert property (r1 && addr_i[9:7] == 3'h4 |=> $stable(additive_latency_o))
    else $error("adjust changed latency");
  drive_high_a: assert property (drv_hi_s |-> &dq_o && &dqs_o && ~|dqs_c_o && ~|dq_oe_n_o)
    else $error("drive-high pattern wrong");
  step_default_a: assert property (dflt_s |=> pullup_step_o == DEFAULT_STEP
    && pulldown_step_o == DEFAULT_STEP) else $error("default step not loaded");
  drive_delay_a: assert property (r1 && addr_i[9:7] == 3'h1 && &dq_oe_n_o |=> &dq_oe_n_o)
    else $error("drivers on before output delay");
  early_flag_a: assert property (mode_set_busy_o && any_c |=> cmd_too_early_o)
    else $error("early command not flagged");
endmodule
bind ext_mode_cal ext_mode_cal_checker #(.DQ_WIDTH(DQ_WIDTH), .DQS_WIDTH(DQS_WIDTH),
  .STEP_WIDTH(STEP_WIDTH), .DEFAULT_STEP(DEFAULT_STEP)) ext_mode_cal_checker_inst (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .ras_n_i(ras_n_i),
  .cas_n_i(cas_n_i), .we_n_i(we_n_i), .bank_addr_0_i(bank_addr_0_i),
  .bank_addr_1_i(bank_addr_1_i), .addr_i(addr_i), .output_off_o(output_off_o),
  .strobe_single_ended_o(strobe_single_ended_o), .additive_latency_o(additive_latency_o),
  .emr2_o(emr2_o), .emr2_valid_o(emr2_valid_o), .mode_set_busy_o(mode_set_busy_o),
  .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dqs_o(dqs_o), .dqs_c_o(dqs_c_o),
  .pullup_step_o(pullup_step_o), .pulldown_step_o(pulldown_step_o),
  .cmd_too_early_o(cmd_too_early_o));

// ### sim/mem_ctrl_model.sv
// Purpose: Memory controller issuing mode set and adjust traffic
// Assumes: All banks idle and clock enable high throughout
// Notes:   Data lines toggle every cycle when no beat is driven
`timescale 1ns/100ps
module mem_ctrl_model #(
  parameter DQ_WIDTH = 16
) (
  // Clock
  input  wire                clk_i,
  // Command bus
  output reg  [3:0]          cmd_n_o,
  output reg  [1:0]          bank_o,
  output reg  [15:0]         addr_o,
  // Adjust code lines
  output wire [DQ_WIDTH-1:0] dq_o
);
  reg beat_on = 1'b0;
  reg beat_val = 1'b0;
  reg tgl = 1'b0;
  initial begin
    cmd_n_o = 4'hF;
    bank_o = 2'h0;
    addr_o = 16'h0000;
  end
  ////////////////////////////////////////
  // Idle pattern so stale levels never pass as code
  always @(posedge clk_i) begin
    tgl <= ~tgl;
  end
  assign dq_o = {DQ_WIDTH{beat_on ? beat_val : tgl}};
  // Deselect, address lines scrambled
  task nop;
    begin
      @(negedge clk_i);
      cmd_n_o = 4'hF;
      addr_o = ~addr_o;
    end
  endtask
  // Mode set write, then quiet for the cycle time
  task wr(input [1:0] b, input [15:0] a);
    begin
      @(negedge clk_i);
      cmd_n_o = 4'h0;
      bank_o = b;
      addr_o = a;
      repeat (3) nop;
    end
  endtask
  // Back-to-back writes that break the cycle time, to provoke the flag
  task wr_pair(input [1:0] b, input [15:0] a);
    begin
      @(negedge clk_i);
      cmd_n_o = 4'h0;
      bank_o = b;
      addr_o = a;
      wr(b, a);
    end
  endtask
  // Adjust command, four beats at write latency, then exit
  task adj(input [3:0] c, input integer wl, input [15:0] a);
    integer i;
    begin
      @(negedge clk_i);
      cmd_n_o = 4'h0;
      bank_o = 2'h1;
      addr_o = a;
      repeat (wl - 1) nop;
      for (i = 0; i < 4; i = i + 1) begin
        nop;
        beat_on = 1'b1;
        beat_val = c[3-i];
      end
      @(negedge clk_i);
      beat_on = 1'b0;
      wr(2'h1, 16'h0000);
    end
  endtask
endmodule

// ### sim/tb_ext_mode_cal.sv
// Purpose: Self-checking bench of the extended mode decoder
// Assumes: Column latency 3, additive latency 0 while adjusting, 1 in the last adjust
// Notes:   Commands come from the controller model tasks
`timescale 1ns/100ps
module tb_ext_mode_cal;
  reg         clk_i = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg  [2:0]  column_latency_i = 3'h3;
  wire [3:0]  cmd_n;
  wire [1:0]  bank;
  wire [15:0] addr, dq, emr2_o, emr3_o, dq_o, dq_oe_n_o;
  wire [2:0]  additive_latency_o, cal_mode_o;
  wire [1:0]  dqs_o, dqs_oe_n_o, dqs_c_o, dqs_c_oe_n_o;
  wire [3:0]  pullup_step_o, pulldown_step_o;
  wire        output_off_o, strobe_single_ended_o, al_reserved_o, emr2_valid_o;
  wire        mode_set_busy_o, cmd_too_early_o, adjust_reserved_o;
  integer     err_count = 0, checked = 0, i, pu = 8, pd = 8;
  reg  [3:0]  codes [0:9];
  always #20 clk_i = ~clk_i;
  ////////////////////////////////////////
  mem_ctrl_model mem_ctrl_model_inst (.clk_i(clk_i), .cmd_n_o(cmd_n), .bank_o(bank),
    .addr_o(addr), .dq_o(dq));
  ext_mode_cal ext_mode_cal_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cmd_n[3]),
    .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]), .bank_addr_0_i(bank[0]),
    .bank_addr_1_i(bank[1]), .addr_i(addr), .column_latency_i(column_latency_i), .dq_i(dq),
    .output_off_o(output_off_o), .strobe_single_ended_o(strobe_single_ended_o),
    .additive_latency_o(additive_latency_o), .al_reserved_o(al_reserved_o),
    .cal_mode_o(cal_mode_o), .emr2_o(emr2_o), .emr2_valid_o(emr2_valid_o), .emr3_o(emr3_o),
    .mode_set_busy_o(mode_set_busy_o), .cmd_too_early_o(cmd_too_early_o), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o), .dqs_o(dqs_o), .dqs_oe_n_o(dqs_oe_n_o), .dqs_c_o(dqs_c_o),
    .dqs_c_oe_n_o(dqs_c_oe_n_o), .pullup_step_o(pullup_step_o),
    .pulldown_step_o(pulldown_step_o), .adjust_reserved_o(adjust_reserved_o));
  // Comparison and verdict
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("FAIL %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  function integer sat(input integer v);
    sat = v < 0 ? 0 : (v > 15 ? 15 : v);
  endfunction
  // Watchdog
  initial begin
    #400000;
    err_count = err_count + 1;
    tally_and_finish;
  end
  ////////////////////////////////////////
  initial begin
    {codes[0], codes[1], codes[2], codes[3], codes[4]} = {4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    {codes[5], codes[6], codes[7], codes[8], codes[9]} = {4'h5, 4'h6, 4'h9, 4'hA, 4'h3};
    repeat (16) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk("emr2_valid", 16'h0000, {15'h0, emr2_valid_o});
    mem_ctrl_model_inst.wr(2'h2, 16'h0087);
    chk("emr2", 16'h0087, emr2_o);
    chk("emr2_valid", 16'h0001, {15'h0, emr2_valid_o});
    mem_ctrl_model_inst.wr(2'h3, 16'h0000);
    chk("emr3", 16'h0000, emr3_o);
    fork
      mem_ctrl_model_inst.wr_pair(2'h2, 16'h0087);
      begin
        repeat (3) @(negedge clk_i);
        chk("too_early", 16'h0001, {15'h0, cmd_too_early_o});
      end
    join
    chk("too_early", 16'h0000, {15'h0, cmd_too_early_o});
    for (i = 0; i < 8; i = i + 1) begin
      mem_ctrl_model_inst.wr(2'h1, i[2:0] << 3);
      chk("latency", (i < 6) ? i : 5, {13'h0, additive_latency_o});
      chk("latency_res", i > 5, {15'h0, al_reserved_o});
    end
    mem_ctrl_model_inst.wr(2'h1, 16'h1000);
    chk("output_off", 16'h0001, {15'h0, output_off_o});
    mem_ctrl_model_inst.wr(2'h1, 16'h0400);
    chk("single_end", 16'h0001, {15'h0, strobe_single_ended_o});
    for (i = 0; i < 2; i = i + 1) begin
      mem_ctrl_model_inst.wr(2'h1, i ? 16'h0500 : 16'h0080);
      repeat (2) @(negedge clk_i);
      chk("dq", i ? 16'h0000 : 16'hFFFF, dq_o);
      chk("dq_oe_n", 16'h0000, dq_oe_n_o);
      chk("dqs_oe_n", 16'h0000, {14'h0, dqs_oe_n_o});
      chk("strobes", i ? 16'h0003 : 16'h000C, {12'h0, dqs_o, dqs_c_o});
      chk("dqs_c_oe_n", i ? 16'h0003 : 16'h0000, {14'h0, dqs_c_oe_n_o});
      mem_ctrl_model_inst.wr(2'h1, 16'h0000);
      repeat (2) @(negedge clk_i);
      chk("dq_oe_n", 16'hFFFF, dq_oe_n_o);
    end
    for (i = 0; i < 36; i = i + 1) begin
      mem_ctrl_model_inst.adj(i < 10 ? codes[i] : (i < 19 ? 4'h5 : 4'hA), 2, 16'h0228);
      if (i != 9) begin
        pu = sat(pu + (i < 10 ? codes[i][0] - codes[i][1] : (i < 19 ? 1 : -1)));
        pd = sat(pd + (i < 10 ? codes[i][2] - codes[i][3] : (i < 19 ? 1 : -1)));
      end
      chk("pullup", pu, {12'h0, pullup_step_o});
      chk("pulldown", pd, {12'h0, pulldown_step_o});
      chk("adj_res", i == 9, {15'h0, adjust_reserved_o});
      chk("latency", 16'h0000, {13'h0, additive_latency_o});
    end
    mem_ctrl_model_inst.wr(2'h1, 16'h0008);
    mem_ctrl_model_inst.adj(4'h1, 3, 16'h0228);
    chk("pullup", 16'h0001, {12'h0, pullup_step_o});
    mem_ctrl_model_inst.wr(2'h1, 16'h0380);
    chk("pullup", 16'h0008, {12'h0, pullup_step_o});
    chk("cal_mode", 16'h0007, {13'h0, cal_mode_o});
    mem_ctrl_model_inst.wr(2'h1, 16'h0000);
    mem_ctrl_model_inst.wr(2'h1, 16'h0010);
    chk("pulldown", 16'h0008, {12'h0, pulldown_step_o});
    tally_and_finish;
  end
endmodule
